// ==== shared/chpm_params.svh ====
/*
 * Constants for the connector pin-function multiplexer: field positions,
 * reset levels and address boundaries.
 * Assumes inclusion by bare name from any file that needs them.
 */
`ifndef CHPM_PARAMS_SVH
`define CHPM_PARAMS_SVH

// ==========================================================================
// Widths and synchroniser vector layout
// ==========================================================================
`define CHPM_ADDR_W    11
`define CHPM_TF_W      3
`define CHPM_BYTE_W    8
`define CHPM_SYNC_W    24
`define CHPM_SYN_ADDR  0
`define CHPM_SYN_REGN  11
`define CHPM_SYN_RD    12
`define CHPM_SYN_WR    13
`define CHPM_SYN_CSELN 14
`define CHPM_SYN_CS2N  15
`define CHPM_SYN_DHI   16

// ==========================================================================
// Address boundary and reset levels
// ==========================================================================
`define CHPM_CFG_BASE  11'h200
`define CHPM_SYNC_RST  24'hFFFFFF

`endif

// ==== shared/chpm_pkg.sv ====
/*
 * Types for the connector pin-function multiplexer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package chpm_pkg;

	// ======================================================================
	// Operating modes and decode targets
	// ======================================================================
	typedef enum logic [2:0] {
		CHPM_MODE_MEM = 3'b001,
		CHPM_MODE_IO  = 3'b010,
		CHPM_MODE_IDE = 3'b100
	} chpm_mode_t;

	typedef enum logic [4:0] {
		CHPM_TGT_NONE = 5'b00001,
		CHPM_TGT_IOR  = 5'b00010,
		CHPM_TGT_MEMR = 5'b00100,
		CHPM_TGT_CIS  = 5'b01000,
		CHPM_TGT_CFG  = 5'b10000
	} chpm_target_t;

endpackage

// ==== rtl/chpm_sync.sv ====
/*
 * Two-stage synchroniser for a vector of asynchronous connector inputs.
 * Assumes each bit is independent; multi-bit buses must be stable while read.
 */
`timescale 1ns/10ps
`include "chpm_params.svh"

module chpm_sync (
	input  wire logic                    core_clk,
	input  wire logic                    reset_n,
	input  wire logic [`CHPM_SYNC_W-1:0] async_in,
	output logic      [`CHPM_SYNC_W-1:0] sync_out
);

	logic [`CHPM_SYNC_W-1:0] meta_r;
	logic [`CHPM_SYNC_W-1:0] meta_nxt;
	logic [`CHPM_SYNC_W-1:0] sync_nxt;

	// ======================================================================
	// Per-bit stages
	// ======================================================================
	// Resetting high keeps the active-low strobes and selects idle.
	genvar gi;
	generate
		for (gi = 0; gi < `CHPM_SYNC_W; gi++) begin : g_bit
			always_comb begin
				meta_nxt[gi] = async_in[gi];
				sync_nxt[gi] = meta_r[gi];
			end
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					meta_r[gi]   <= 1'b1;
					sync_out[gi] <= 1'b1;
				end else begin
					meta_r[gi]   <= meta_nxt[gi];
					sync_out[gi] <= sync_nxt[gi];
				end
			end
		end
	endgenerate

endmodule

// ==== rtl/chpm_pin_mux.sv ====
/*
 * Mode-dependent pin-function multiplexer for the upper connector half:
 * upper data byte, second chip select, strobes, wait, register select,
 * cable select, status pin, plus address decoding per mode.
 * Assumes the mode, burst state and card-side signals come from logic on
 * core_clk, and that connector inputs are asynchronous.
 */
// Functional notes
// - IDE decodes only A2..A0 into eight registers.
// - Cable select ignored in both card modes.
// - IDE non-burst: read, write strobes, ready out.
// - Write burst: host strobe, stop; device ready.
// - Read burst: host ready, stop; device strobe.
// - Card modes: space select picks target, plus address in memory mode.
// - Memory mode drives battery detect one high.
// - Upper byte, second select optional for 8-bit.
// - I/O mode status change low, config gated.
`timescale 1ns/10ps
`include "chpm_params.svh"

module chpm_pin_mux
	import chpm_pkg::*;
(
	input  wire logic                    core_clk,
	input  wire logic                    reset_n,
	input  wire chpm_mode_t              mode_sel,
	input  wire logic                    udma_active,
	input  wire logic                    udma_read,
	input  wire logic                    word16,
	input  wire logic [`CHPM_ADDR_W-1:0] addr_pin,
	input  wire logic                    reg_n_pin,
	input  wire logic                    rd_strobe_pin,
	input  wire logic                    wr_strobe_pin,
	input  wire logic                    csel_n_pin,
	input  wire logic                    cs2_n_pin,
	input  wire logic [`CHPM_BYTE_W-1:0] data_hi_pin_i,
	input  wire logic [`CHPM_BYTE_W-1:0] card_data_hi,
	input  wire logic                    card_data_hi_oe,
	input  wire logic                    card_wait_n,
	input  wire logic                    card_iordy,
	input  wire logic                    card_ddmardy_n,
	input  wire logic                    card_dstrobe,
	input  wire logic                    card_ready,
	input  wire logic                    card_wp,
	input  wire logic                    stschg_enable,
	input  wire logic                    stschg_ack,
	output logic [`CHPM_BYTE_W-1:0]      data_hi_pin_o,
	output logic                         data_hi_pin_oe,
	output logic                         wait_pin_o,
	output logic                         status_pin_o,
	output logic                         status_pin_oe,
	output logic [`CHPM_BYTE_W-1:0]      host_data_hi,
	output logic                         host_data_hi_valid,
	output chpm_target_t                 target,
	output logic [`CHPM_TF_W-1:0]        tf_reg_sel,
	output logic                         io_rd_n,
	output logic                         io_wr_n,
	output logic                         hstrobe,
	output logic                         hdmardy_n,
	output logic                         udma_stop,
	output logic                         cable_sel,
	output logic                         dmack_n
);

	// ======================================================================
	// Input synchronisation
	// ======================================================================
	logic [`CHPM_SYNC_W-1:0] s_vec;
	logic [`CHPM_ADDR_W-1:0] s_addr;
	logic [`CHPM_BYTE_W-1:0] s_dhi;
	logic                    s_reg_n;
	logic                    s_rd;
	logic                    s_wr;
	logic                    s_csel_n;
	logic                    s_cs2_n;

	chpm_sync u_sync (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.async_in ({data_hi_pin_i, cs2_n_pin, csel_n_pin, wr_strobe_pin,
		            rd_strobe_pin, reg_n_pin, addr_pin}),
		.sync_out (s_vec)
	);

	assign s_addr   = s_vec[`CHPM_SYN_ADDR +: `CHPM_ADDR_W];
	assign s_reg_n  = s_vec[`CHPM_SYN_REGN];
	assign s_rd     = s_vec[`CHPM_SYN_RD];
	assign s_wr     = s_vec[`CHPM_SYN_WR];
	assign s_csel_n = s_vec[`CHPM_SYN_CSELN];
	assign s_cs2_n  = s_vec[`CHPM_SYN_CS2N];
	assign s_dhi    = s_vec[`CHPM_SYN_DHI +: `CHPM_BYTE_W];

	// ======================================================================
	// Next-state logic
	// ======================================================================
	logic                    is_mem;
	logic                    is_io;
	logic                    is_ide;
	logic                    burst;
	logic                    ready_d_r;
	logic                    wp_d_r;
	logic                    chg_r;
	logic                    chg_nxt;
	logic                    upper_ok;
	logic [`CHPM_BYTE_W-1:0] data_hi_pin_o_nxt;
	logic                    data_hi_pin_oe_nxt;
	logic                    wait_pin_o_nxt;
	logic                    status_pin_o_nxt;
	logic                    status_pin_oe_nxt;
	logic [`CHPM_BYTE_W-1:0] host_data_hi_nxt;
	logic                    host_data_hi_valid_nxt;
	chpm_target_t            target_nxt;
	logic [`CHPM_TF_W-1:0]   tf_reg_sel_nxt;
	logic                    io_rd_n_nxt;
	logic                    io_wr_n_nxt;
	logic                    hstrobe_nxt;
	logic                    hdmardy_n_nxt;
	logic                    udma_stop_nxt;
	logic                    cable_sel_nxt;
	logic                    dmack_n_nxt;

	always_comb begin
		is_mem = (mode_sel == CHPM_MODE_MEM);
		is_io  = (mode_sel == CHPM_MODE_IO);
		is_ide = (mode_sel == CHPM_MODE_IDE);
		burst  = is_ide && udma_active;

		// A change seen on the same edge as the acknowledge is kept.
		chg_nxt = (chg_r && !stschg_ack) ||
		          (card_ready != ready_d_r) || (card_wp != wp_d_r);

		// Upper lane is live only for a word access with the second select low.
		upper_ok               = word16 && !s_cs2_n;
		data_hi_pin_o_nxt      = card_data_hi;
		data_hi_pin_oe_nxt     = upper_ok && card_data_hi_oe;
		host_data_hi_nxt       = upper_ok ? s_dhi : 8'h00;
		host_data_hi_valid_nxt = upper_ok;

		tf_reg_sel_nxt = is_ide ? s_addr[`CHPM_TF_W-1:0] : 3'h0;
		target_nxt     = CHPM_TGT_NONE;
		if (is_mem && s_reg_n) begin
			target_nxt = CHPM_TGT_MEMR;
		end else if (is_io && !s_reg_n) begin
			target_nxt = CHPM_TGT_IOR;
		end else if (!is_ide && !s_reg_n && s_addr >= `CHPM_CFG_BASE) begin
			target_nxt = CHPM_TGT_CFG;
		end else if (!is_ide && !s_reg_n) begin
			target_nxt = CHPM_TGT_CIS;
		end

		// Strobes go to one function per I/O or IDE mode and burst state, and to none in memory mode.
		io_rd_n_nxt   = (is_io || (is_ide && !burst)) ? s_rd : 1'b1;
		io_wr_n_nxt   = (is_io || (is_ide && !burst)) ? s_wr : 1'b1;
		hstrobe_nxt   = (burst && !udma_read) ? s_rd : 1'b0;
		hdmardy_n_nxt = (burst && udma_read) ? s_rd : 1'b1;
		udma_stop_nxt = burst ? s_wr : 1'b0;

		// Card modes leave cable select unpulled, so it must not reach logic.
		cable_sel_nxt = is_ide ? !s_csel_n : 1'b0;
		dmack_n_nxt   = is_ide ? s_reg_n : 1'b1;

		if (!is_ide) begin
			wait_pin_o_nxt = card_wait_n;
		end else if (!burst) begin
			wait_pin_o_nxt = card_iordy;
		end else if (!udma_read) begin
			wait_pin_o_nxt = card_ddmardy_n;
		end else begin
			wait_pin_o_nxt = card_dstrobe;
		end

		// The diagnostic handshake in IDE belongs elsewhere; release the pin.
		status_pin_o_nxt  = 1'b1;
		status_pin_oe_nxt = !is_ide;
		if (is_io) begin
			status_pin_o_nxt = !(stschg_enable && chg_r);
		end
	end

	// ======================================================================
	// Registers
	// ======================================================================
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			// Ready resets to its idle level so that leaving reset is not seen as a change.
			ready_d_r          <= 1'b1;
			wp_d_r             <= 1'b0;
			chg_r              <= 1'b0;
			data_hi_pin_o      <= 8'h00;
			data_hi_pin_oe     <= 1'b0;
			wait_pin_o         <= 1'b1;
			status_pin_o       <= 1'b1;
			status_pin_oe      <= 1'b0;
			host_data_hi       <= 8'h00;
			host_data_hi_valid <= 1'b0;
			target             <= CHPM_TGT_NONE;
			tf_reg_sel         <= 3'h0;
			io_rd_n            <= 1'b1;
			io_wr_n            <= 1'b1;
			hstrobe            <= 1'b0;
			hdmardy_n          <= 1'b1;
			udma_stop          <= 1'b0;
			cable_sel          <= 1'b0;
			dmack_n            <= 1'b1;
		end else begin
			ready_d_r          <= card_ready;
			wp_d_r             <= card_wp;
			chg_r              <= chg_nxt;
			data_hi_pin_o      <= data_hi_pin_o_nxt;
			data_hi_pin_oe     <= data_hi_pin_oe_nxt;
			wait_pin_o         <= wait_pin_o_nxt;
			status_pin_o       <= status_pin_o_nxt;
			status_pin_oe      <= status_pin_oe_nxt;
			host_data_hi       <= host_data_hi_nxt;
			host_data_hi_valid <= host_data_hi_valid_nxt;
			target             <= target_nxt;
			tf_reg_sel         <= tf_reg_sel_nxt;
			io_rd_n            <= io_rd_n_nxt;
			io_wr_n            <= io_wr_n_nxt;
			hstrobe            <= hstrobe_nxt;
			hdmardy_n          <= hdmardy_n_nxt;
			udma_stop          <= udma_stop_nxt;
			cable_sel          <= cable_sel_nxt;
			dmack_n            <= dmack_n_nxt;
		end
	end

	// ======================================================================
	// Checks
	// ======================================================================
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence s_wr_burst;
		(mode_sel == CHPM_MODE_IDE) && udma_active && !udma_read;
	endsequence
	sequence s_rd_burst;
		(mode_sel == CHPM_MODE_IDE) && udma_active && udma_read;
	endsequence

	chk_ide_tf_sel: assert property ((mode_sel == CHPM_MODE_IDE) |=>
		tf_reg_sel == $past(s_addr[2:0]))
		else $error("Task-file select does not follow low address bits.");
	chk_csel_ignored: assert property ((mode_sel != CHPM_MODE_IDE) |=> !cable_sel)
		else $error("Cable select reached logic in a card mode.");
	chk_ide_plain: assert property ((mode_sel == CHPM_MODE_IDE) && !udma_active |=>
		io_rd_n == $past(s_rd) && wait_pin_o == $past(card_iordy) && !hstrobe)
		else $error("Plain IDE routing of strobes or ready is wrong.");
	chk_wr_burst: assert property (s_wr_burst |=> hstrobe == $past(s_rd) && io_rd_n
		&& wait_pin_o == $past(card_ddmardy_n) && udma_stop == $past(s_wr))
		else $error("Write burst routing is wrong.");
	chk_rd_burst: assert property (s_rd_burst |=> hdmardy_n == $past(s_rd) && !hstrobe
		&& wait_pin_o == $past(card_dstrobe))
		else $error("Read burst routing is wrong.");
	chk_cfg_target: assert property ((mode_sel == CHPM_MODE_MEM) && !s_reg_n
		&& s_addr >= `CHPM_CFG_BASE |=> target == CHPM_TGT_CFG)
		else $error("Configuration space not decoded.");
	chk_mem_bvd: assert property ((mode_sel == CHPM_MODE_MEM) |=>
		status_pin_o && status_pin_oe)
		else $error("Battery detect pin not held high.");
	chk_upper_idle: assert property (!word16 || s_cs2_n |=>
		!data_hi_pin_oe && !host_data_hi_valid)
		else $error("Upper byte active without a word access.");
	chk_stschg: assert property ((mode_sel == CHPM_MODE_IO) && stschg_enable
		&& ((card_ready != ready_d_r) || (card_wp != wp_d_r))
		##1 (mode_sel == CHPM_MODE_IO) && stschg_enable
		|=> !status_pin_o)
		else $error("Status change not signalled.");

endmodule

// ==== test/chpm_host_model.sv ====
/*
 * Behavioural host controller across the connector from the pin multiplexer.
 * It turns the bench's requested levels into connector pin levels.
 * Assumes the bench changes its requests just after a falling clock edge.
 */
`timescale 1ns/10ps
`include "chpm_params.svh"

module chpm_host_model
	import chpm_pkg::*;
(
	input  wire chpm_mode_t              mode_sel,
	input  wire logic                    dma_on,
	input  wire logic                    rude,
	input  wire logic                    a25,
	input  wire logic [`CHPM_ADDR_W-1:0] req_addr,
	input  wire logic                    req_reg_n,
	input  wire logic                    req_rd_n,
	input  wire logic                    req_wr_n,
	input  wire logic                    req_csel_n,
	output logic      [`CHPM_ADDR_W-1:0] addr_pin,
	output logic                         reg_n_pin,
	output logic                         rd_strobe_pin,
	output logic                         wr_strobe_pin,
	output logic                         csel_n_pin,
	output logic                         wr_en_n
);
	logic ide;

	assign ide = (mode_sel == CHPM_MODE_IDE);
	// A careless host is modelled only when a scenario asks for it.
	assign addr_pin = (ide && !rude) ? {8'h00, req_addr[2:0]} : req_addr;
	assign csel_n_pin = ide ? req_csel_n : a25;
	assign reg_n_pin = (ide && !dma_on) ? 1'b1 : req_reg_n;
	assign wr_en_n = 1'b1;
	assign rd_strobe_pin = req_rd_n;
	assign wr_strobe_pin = req_wr_n;
endmodule

// ==== test/tb_card_host_pin_mode_mux.sv ====
/*
 * Self-checking bench for the connector pin-function multiplexer.
 * Assumes the host model drives the address and strobe pins and that the
 * upper data wire is resolved here from the multiplexer's enable alone.
 */
`timescale 1ns/10ps
`include "chpm_params.svh"

module tb_card_host_pin_mode_mux
	import chpm_pkg::*;
;
	logic core_clk = 1'b0, reset_n = 1'b0, udma_active = 1'b0, udma_read = 1'b0, word16 = 1'b0;
	logic card_data_hi_oe = 1'b0, card_wait_n = 1'b1, card_iordy = 1'b1, card_ddmardy_n = 1'b1;
	logic card_dstrobe = 1'b0, card_ready = 1'b1, card_wp = 1'b0, stschg_enable = 1'b0;
	logic stschg_ack = 1'b0, cs2_n_pin = 1'b1, dma_on = 1'b0, rude = 1'b0, a25 = 1'b0;
	logic req_reg_n = 1'b1, req_rd_n = 1'b1, req_wr_n = 1'b1, req_csel_n = 1'b1;
	logic [7:0]  card_data_hi = 8'h00, host_data = 8'h00;
	logic [10:0] req_addr = 11'h000;
	chpm_mode_t  mode_sel = CHPM_MODE_MEM;
	chpm_mode_t  modes [3] = '{CHPM_MODE_MEM, CHPM_MODE_IO, CHPM_MODE_IDE};
	logic [10:0] addr_pin;
	logic [7:0]  data_hi_pin_i, data_hi_pin_o, host_data_hi;
	logic [2:0]  tf_reg_sel;
	logic        reg_n_pin, rd_strobe_pin, wr_strobe_pin, csel_n_pin, ide;
	logic        data_hi_pin_oe, wait_pin_o, status_pin_o, status_pin_oe, host_data_hi_valid;
	logic        io_rd_n, io_wr_n, hstrobe, hdmardy_n, udma_stop, cable_sel, dmack_n;
	chpm_target_t target;
	integer      seed;
	int          miscompares = 0, n_tests = 0, k;

	always #12.5 core_clk = ~core_clk;
	assign ide = (mode_sel == CHPM_MODE_IDE);
	assign data_hi_pin_i = data_hi_pin_oe ? data_hi_pin_o : host_data;

	chpm_host_model u_host (.mode_sel, .dma_on, .rude, .a25, .req_addr, .req_reg_n, .req_rd_n,
		.req_wr_n, .req_csel_n, .addr_pin, .reg_n_pin, .rd_strobe_pin, .wr_strobe_pin,
		.csel_n_pin, .wr_en_n());

	chpm_pin_mux u_dut (.core_clk, .reset_n, .mode_sel, .udma_active, .udma_read, .word16,
		.addr_pin, .reg_n_pin, .rd_strobe_pin, .wr_strobe_pin, .csel_n_pin, .cs2_n_pin,
		.data_hi_pin_i, .card_data_hi, .card_data_hi_oe, .card_wait_n, .card_iordy,
		.card_ddmardy_n, .card_dstrobe, .card_ready, .card_wp, .stschg_enable, .stschg_ack,
		.data_hi_pin_o, .data_hi_pin_oe, .wait_pin_o, .status_pin_o, .status_pin_oe,
		.host_data_hi, .host_data_hi_valid, .target, .tf_reg_sel, .io_rd_n, .io_wr_n,
		.hstrobe, .hdmardy_n, .udma_stop, .cable_sel, .dmack_n);

	// ======================================================================
	// Checking helpers
	// ======================================================================
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Pin inputs cross two sync flops and one output register, so four edges suffice.
	task automatic settle;
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
	endtask

	task automatic pulse_ack;
		stschg_ack = 1'b1;
		@(negedge core_clk);
		stschg_ack = 1'b0;
	endtask

	function automatic chpm_target_t exp_tgt(chpm_mode_t m, logic rn, logic [10:0] a);
		if (m == CHPM_MODE_MEM && !rn)
			return (a >= `CHPM_CFG_BASE) ? CHPM_TGT_CFG : CHPM_TGT_CIS;
		if (m == CHPM_MODE_MEM)
			return CHPM_TGT_MEMR;
		if (m == CHPM_MODE_IO && !rn)
			return CHPM_TGT_IOR;
		return CHPM_TGT_NONE;
	endfunction

	initial begin
		#125000;
		miscompares++;
		close_out();
	end

	// ======================================================================
	// Main sequence
	// ======================================================================
	initial begin
		seed = 32'hbbc5;
		repeat (10) @(negedge core_clk);
		check(16'({wait_pin_o, io_rd_n, io_wr_n, status_pin_oe, data_hi_pin_oe}), 16'h001C);
		check(16'(target), 16'(CHPM_TGT_NONE));
		repeat (2) @(negedge core_clk);
		reset_n = 1'b1;
		for (int i = 0; i < 40; i++) begin
			mode_sel = modes[$unsigned($random(seed)) % 3];
			{req_addr, req_reg_n, req_rd_n, req_wr_n, req_csel_n, a25, cs2_n_pin, host_data,
				word16, card_data_hi_oe, card_wait_n, card_iordy} = 29'($random(seed));
			card_data_hi = 8'($random(seed));
			if (i < 6)
				req_addr = 11'h1FF + 11'(i % 2);
			settle();
			check(16'(target), 16'(exp_tgt(mode_sel, req_reg_n, req_addr)));
			check(16'(tf_reg_sel), ide ? 16'(req_addr[2:0]) : 16'h0000);
			check(16'({io_rd_n, io_wr_n}),
				(mode_sel == CHPM_MODE_MEM) ? 16'h0003 : 16'({req_rd_n, req_wr_n}));
			check(16'(wait_pin_o), 16'(ide ? card_iordy : card_wait_n));
			check(16'(cable_sel), 16'(ide && !req_csel_n));
			if (mode_sel == CHPM_MODE_MEM)
				check(16'({status_pin_o, status_pin_oe}), 16'h0003);
			if (ide)
				check(16'({status_pin_oe, dmack_n}), 16'h0001);
			if (!card_data_hi_oe)
				check(16'({host_data_hi_valid, host_data_hi}),
					(word16 && !cs2_n_pin) ? 16'({1'b1, host_data}) : 16'h0000);
			check(16'({data_hi_pin_oe, data_hi_pin_o & {8{data_hi_pin_oe}}}),
				(card_data_hi_oe && word16 && !cs2_n_pin) ? 16'({1'b1, card_data_hi}) :
				16'h0000);
		end
		mode_sel = CHPM_MODE_IDE;
		udma_active = 1'b1;
		dma_on = 1'b1;
		for (int i = 0; i < 8; i++) begin
			udma_read = i[0];
			{req_rd_n, req_wr_n, req_reg_n, card_ddmardy_n, card_dstrobe} = 5'($random(seed));
			settle();
			if (udma_read)
				check(16'({hdmardy_n, udma_stop, wait_pin_o}),
					16'({req_rd_n, req_wr_n, card_dstrobe}));
			else
				check(16'({hstrobe, udma_stop, wait_pin_o}),
					16'({req_rd_n, req_wr_n, card_ddmardy_n}));
			check(16'({io_rd_n, io_wr_n, dmack_n}), 16'({2'b11, req_reg_n}));
		end
		udma_active = 1'b0;
		dma_on = 1'b0;
		rude = 1'b1;
		req_addr = 11'h7F5;
		settle();
		check(16'({tf_reg_sel, target}), 16'({3'h5, CHPM_TGT_NONE}));
		rude = 1'b0;
		mode_sel = CHPM_MODE_IO;
		stschg_enable = 1'b1;
		pulse_ack();
		settle();
		check(16'({status_pin_o, status_pin_oe}), 16'h0003);
		card_wp = ~card_wp;
		@(posedge core_clk);
		@(negedge core_clk);
		check(16'(status_pin_o), 16'h0001);
		@(negedge core_clk);
		check(16'(status_pin_o), 16'h0000);
		settle();
		check(16'(status_pin_o), 16'h0000);
		pulse_ack();
		k = 0;
		while (status_pin_o !== 1'b1 && k < 4) begin
			@(negedge core_clk);
			k++;
		end
		check(16'(k < 4), 16'h0001);
		close_out();
	end
endmodule
